// >>> verilog/fws_pkg.sv
package fws_pkg;

  // ***************************************************************
  // bus and data bit positions
  // ***************************************************************
  localparam int ADDR_W       = 20;
  localparam int DATA_W       = 8;
  localparam int POLL_BIT     = 7;
  localparam int TOGGLE_BIT   = 6;
  localparam int TIMEOUT_BIT  = 5;
  localparam int SECTOR_BIT   = 2;

  localparam logic [7:0] RESET_CMD = 8'hF0;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int RD_ACCESS_NS  = 100;   // strobe low time per read
  localparam int WR_PULSE_NS   = 100;   // strobe low time per write
  localparam int RD_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W  = 4;

  // ***************************************************************
  // result codes and sequencer states
  // ***************************************************************
  typedef enum logic [1:0] {
    FWS_RES_DONE    = 2'b00,
    FWS_RES_FAIL    = 2'b01,
    FWS_RES_SUSPEND = 2'b10,
    FWS_RES_NONE    = 2'b11
  } fws_result_e;

  typedef enum logic [3:0] {
    FWS_IDLE    = 4'b0000,
    FWS_RD_LOW  = 4'b0001,
    FWS_RD_HIGH = 4'b0010,
    FWS_EVAL    = 4'b0011,
    FWS_FINAL   = 4'b0100,
    FWS_WR_LOW  = 4'b0101,
    FWS_WR_HIGH = 4'b0110,
    FWS_DONE    = 4'b0111
  } fws_state_e;

  // user-side request
  typedef struct packed {
    logic              usePoll;    // 1 polling algorithm, 0 toggle
    logic              useCe;      // strobe reads with chip enable
    logic              isErase;    // erase status expected
    logic [ADDR_W-1:0] addr;       // program address or erased sector
    logic [DATA_W-1:0] expData;    // programmed datum
  } fws_req_s;

  // flash pin outputs
  typedef struct packed {
    logic              ceN;
    logic              oeN;
    logic              weN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic              dqOe;
  } fws_pins_s;

endpackage : fws_pkg

// >>> verilog/fws_status_poller.sv
`timescale 1ns/1ps
// Operation
// - host drives the programmed address while polling a program
// - host polls erase with an address inside a selected sector
// - after true data seen, host takes data from a later read
// - host rereads polling bit after seeing the timeout flag
// - reads may be strobed by output enable or chip enable
// - host starts toggle check with two back-to-back reads
// - toggling with timeout set: retest, still toggling means fail, reset
// - after pausing, host restarts toggle algorithm from double read
// - reset command F0 at any address returns to array read
module fws_status_poller
  import fws_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              reqValid,
  input  wire fws_req_s          req,
  output logic                   reqReady,
  output logic                   resValid,
  output fws_result_e            result,
  output logic [DATA_W-1:0]      resData,
  output fws_pins_s              pins,
  input  wire logic [DATA_W-1:0] dqIn,
  input  wire logic              readyBusyIn
);

  // ***************************************************************
  // state
  // ***************************************************************
  fws_state_e        state_reg;
  fws_req_s          req_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [DATA_W-1:0] prev_reg;
  logic [DATA_W-1:0] cur_reg;
  logic [1:0]        nRead_reg;   // reads taken since algorithm start
  logic              toRecheck_reg;
  logic              sendReset_reg;

  wire logic togDiff = cur_reg[TOGGLE_BIT] ^ prev_reg[TOGGLE_BIT];
  wire logic pollTrue = req_reg.isErase ? cur_reg[POLL_BIT]
                      : (cur_reg[POLL_BIT] == req_reg.expData[POLL_BIT]);

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // one always_ff for the algorithm control
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg     <= FWS_IDLE;
      req_reg       <= '0;
      cnt_reg       <= '0;
      prev_reg      <= '0;
      cur_reg       <= '0;
      nRead_reg     <= '0;
      toRecheck_reg <= 1'b0;
      sendReset_reg <= 1'b0;
      resValid      <= 1'b0;
      result        <= FWS_RES_NONE;
      resData       <= '0;
      reqReady      <= 1'b0;
    end else begin
      resValid <= 1'b0;
      case (state_reg)
        FWS_IDLE: begin
          reqReady <= 1'b1;
          if (reqValid && reqReady) begin
            req_reg       <= req;
            reqReady      <= 1'b0;
            nRead_reg     <= '0;
            toRecheck_reg <= 1'b0;
            sendReset_reg <= 1'b0;
            cnt_reg       <= '0;
            state_reg     <= FWS_RD_LOW;
          end
        end
        FWS_RD_LOW: begin
          if (cnt_reg == CNT_W'(RD_CYC - 1)) begin
            cur_reg   <= dqIn;
            prev_reg  <= cur_reg;
            cnt_reg   <= '0;
            state_reg <= FWS_RD_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        FWS_RD_HIGH: begin
          // strobe high one cycle closes the read cycle
          if (nRead_reg != 2'd3) begin
            nRead_reg <= nRead_reg + 1'b1;
          end
          state_reg <= FWS_EVAL;
        end
        FWS_EVAL: begin
          if (req_reg.usePoll) begin
            if (pollTrue) begin
              state_reg <= FWS_FINAL;
            end else if (toRecheck_reg) begin
              sendReset_reg <= 1'b1;
              state_reg     <= FWS_WR_LOW;
            end else begin
              toRecheck_reg <= cur_reg[TIMEOUT_BIT];
              state_reg     <= FWS_RD_LOW;
            end
          end else if (nRead_reg < 2'd2) begin
            state_reg <= FWS_RD_LOW;
          end else if (!togDiff) begin
            // toggling stopped: a suspended erase still has busy released
            if (req_reg.isErase && readyBusyIn && cur_reg[POLL_BIT] &&
                (cur_reg[SECTOR_BIT] ^ prev_reg[SECTOR_BIT])) begin
              result    <= FWS_RES_SUSPEND;
              resValid  <= 1'b1;
              state_reg <= FWS_DONE;
            end else begin
              state_reg <= FWS_FINAL;
            end
          end else if (toRecheck_reg) begin
            sendReset_reg <= 1'b1;
            state_reg     <= FWS_WR_LOW;
          end else begin
            toRecheck_reg <= cur_reg[TIMEOUT_BIT];
            state_reg     <= FWS_RD_LOW;
          end
        end
        FWS_FINAL: begin
          // one more read yields valid array data
          if (cnt_reg == CNT_W'(RD_CYC - 1)) begin
            resData   <= dqIn;
            result    <= FWS_RES_DONE;
            resValid  <= 1'b1;
            cnt_reg   <= '0;
            state_reg <= FWS_DONE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        FWS_WR_LOW: begin
          if (cnt_reg == CNT_W'(WR_CYC - 1)) begin
            cnt_reg   <= '0;
            state_reg <= FWS_WR_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        FWS_WR_HIGH: begin
          result    <= FWS_RES_FAIL;
          resData   <= cur_reg;
          resValid  <= 1'b1;
          state_reg <= FWS_DONE;
        end
        FWS_DONE: begin
          state_reg <= FWS_IDLE;
        end
        default: begin
          state_reg <= FWS_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // flash pins, registered
  // ***************************************************************
  wire logic rdLow = (state_reg == FWS_RD_LOW) || (state_reg == FWS_FINAL);
  wire logic wrLow = (state_reg == FWS_WR_LOW);

  // strobe pins from the current sequencer state, one cycle behind it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0,
                dqOut: '0, dqOe: 1'b0};
    end else begin
      // chip enable strobes reads and the write when selected, else low outside idle
      pins.ceN   <= req_reg.useCe ? !rdLow && !wrLow
                                  : (state_reg == FWS_IDLE);
      pins.oeN   <= req_reg.useCe ? !(rdLow || state_reg == FWS_RD_HIGH)
                                  : !rdLow;
      pins.weN   <= !wrLow;
      pins.addr  <= req_reg.addr;
      pins.dqOut <= RESET_CMD;
      // data stays driven one cycle past the write strobe rising edge
      pins.dqOe  <= wrLow || (state_reg == FWS_WR_HIGH);
    end
  end

endmodule : fws_status_poller

// >>> testbench/fws_status_poller_asserts.sv
`timescale 1ns/1ps
// ****
// port checker for the status poller
// ****
module fws_status_poller_asserts
  import fws_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              reqValid,
  input wire fws_req_s          req,
  input wire logic              reqReady,
  input wire logic              resValid,
  input wire fws_result_e       result,
  input wire logic [DATA_W-1:0] resData,
  input wire fws_pins_s         pins,
  input wire logic [DATA_W-1:0] dqIn,
  input wire logic              readyBusyIn
);
  logic [ADDR_W-1:0] addrCap;
  logic              wrSeen;
  logic              rdQ;
  logic [3:0]        rdCnt;
  wire               rdOn = !pins.ceN && !pins.oeN;
  // address, write and read count of the current request
  always_ff @(posedge core_clk) begin
    rdQ <= rdOn;
    if (reqValid && reqReady) addrCap <= req.addr;
    if (!rst_b || (reqValid && reqReady)) begin
      wrSeen <= 1'h0;
      rdCnt <= 4'h0;
    end else begin
      if (!pins.weN) wrSeen <= 1'h1;
      if (rdOn && !rdQ && rdCnt != 4'hF) rdCnt <= rdCnt + 4'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_read;
    rdOn [*2] ##1 !rdOn;
  endsequence
  sequence s_write;
    !pins.weN [*2] ##1 pins.weN;
  endsequence
  a_read_len: assert property (rdOn && !rdQ |-> s_read)
    else $error("read strobe length wrong");
  a_addr_kept: assert property (rdOn |-> pins.addr == addrCap)
    else $error("read address not the request address");
  a_bus_free: assert property (rdOn |-> !pins.dqOe)
    else $error("data driven during read");
  a_reset_cmd: assert property (!pins.weN |-> pins.oeN && pins.dqOe &&
    pins.dqOut == RESET_CMD) else $error("bad reset command write");
  a_write_len: assert property ($fell(pins.weN) |-> s_write)
    else $error("write strobe length wrong");
  a_fail_reset: assert property (resValid && result == FWS_RES_FAIL
    |-> wrSeen) else $error("fail without reset command");
  a_done_clean: assert property (resValid && result == FWS_RES_DONE
    |-> !wrSeen && rdCnt >= 4'h2) else $error("done too early");
  a_one_pulse: assert property (resValid |=> !resValid ##[0:1] reqReady)
    else $error("answer pulse or return to idle wrong");
  a_suspend_ok: assert property (resValid &&
    result == FWS_RES_SUSPEND |-> readyBusyIn) else $error("suspend while busy");
endmodule : fws_status_poller_asserts
bind fws_status_poller fws_status_poller_asserts fws_status_poller_asserts_i (
  .core_clk, .rst_b, .reqValid, .req, .reqReady, .resValid, .result,
  .resData, .pins, .dqIn, .readyBusyIn);

// >>> testbench/fws_flash_model.sv
`timescale 1ns/1ps
// ****
// flash status behaviour at the host pins
// ****
module fws_flash_model
  import fws_pkg::*;
(
  input  wire fws_pins_s   pins,
  input  wire logic        load,
  input  wire logic [1:0]  op,
  input  wire logic [3:0]  busyRd,
  input  wire logic        fail,
  output logic [DATA_W-1:0] dq,
  output logic             readyBusyN
);
  logic [1:0] mode; // 0 array 1 program 2 erase 3 suspend
  logic [3:0] cnt;
  logic       tog;
  logic       flt;
  logic [7:0] st;
  wire        rdOn = !pins.ceN && !pins.oeN;
  // start in array read
  initial begin
    mode = 2'h0;
    tog = 1'h0;
    flt = 1'h0;
    cnt = 4'h0;
  end
  // operation loaded by the bench, status valid at once
  always @(posedge load) begin
    mode = op;
    cnt = busyRd;
    flt = 1'h0;
  end
  // toggles flip once per completed read, oe or ce strobed
  always @(posedge (pins.ceN | pins.oeN)) begin
    tog = !tog;
    if (mode != 2'h3 && cnt != 4'h0) cnt = cnt - 4'h1;
    else if (mode != 2'h3 && fail) flt = 1'h1;
    else if (mode != 2'h3) mode = 2'h0;
  end
  // reset command at any address
  always @(posedge pins.weN)
    if (pins.dqOe && pins.dqOut == RESET_CMD) mode = 2'h0;
  // status byte per mode
  always_comb begin
    case (mode)
      2'h1: st = {1'h0, tog, flt, 5'h00};
      2'h2: st = {1'h0, tog, flt, 2'h0, tog, 2'h0};
      2'h3: st = {1'h1, 2'h0, 2'h0, tog, 2'h0};
      default: st = 8'hA5;
    endcase
  end
  assign dq = rdOn ? st : ~st; // released bus shows no stale value
  assign readyBusyN = !(mode == 2'h1 || mode == 2'h2);
endmodule : fws_flash_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
// ****
// status poller bench
// ****
module testbench
  import fws_pkg::*;
;
  logic              core_clk = 1'h0;
  logic              rst_b = 1'h0;
  logic              reqValid = 1'h0;
  fws_req_s          req = '0;
  logic              reqReady;
  logic              resValid;
  fws_result_e       result;
  logic [DATA_W-1:0] resData;
  logic [DATA_W-1:0] dqIn;
  fws_pins_s         pins;
  logic              readyBusyIn;
  logic              load = 1'h0;
  logic [1:0]        op = 2'h0;
  logic [3:0]        busyRd = 4'h0;
  logic              fail = 1'h0;
  int                err_count = 0;
  int                num_checks = 0;
  int                cycles = 0;
  fws_status_poller fws_status_poller_i (.core_clk, .rst_b, .reqValid, .req,
    .reqReady, .resValid, .result, .resData, .pins, .dqIn, .readyBusyIn);
  fws_flash_model fws_flash_model_i (.pins, .load, .op, .busyRd, .fail,
    .dq(dqIn), .readyBusyN(readyBusyIn));
  // clock and hang guard
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test;
    end
  end
  task automatic chk_res(input fws_result_e seen, input fws_result_e exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch result exp %0d seen %0d", exp, seen);
    end
  endtask : chk_res
  task automatic chk_data(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch resData exp %h seen %h", exp, seen);
    end
  endtask : chk_data
  // one request against a loaded flash state
  task automatic run(input logic p, input logic c, input logic e,
    input logic [1:0] o, input logic [3:0] n, input logic f,
    input fws_result_e exp);
    int k;
    k = 0;
    while (reqReady !== 1'h1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    op = o;
    busyRd = n;
    fail = f;
    load = 1'h1;
    req = '{p, c, e, {16'h1234, n}, 8'hA5};
    reqValid = 1'h1;
    @(negedge core_clk);
    reqValid = 1'h0;
    load = 1'h0;
    while (resValid !== 1'h1 && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    // no answer within the limit counts as a mismatch
    if (k >= 300) begin
      err_count++;
      end_of_test;
    end else begin
      chk_res(result, exp);
      if (exp == FWS_RES_DONE) chk_data(resData, 8'hA5);
      if (exp == FWS_RES_FAIL) chk_data(resData & 8'h20, 8'h20);
    end
  endtask : run
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'h1;
    run(1'h0, 1'h0, 1'h0, 2'h1, 4'h3, 1'h0, FWS_RES_DONE);
    run(1'h1, 1'h1, 1'h0, 2'h1, 4'h2, 1'h0, FWS_RES_DONE);
    run(1'h1, 1'h0, 1'h1, 2'h2, 4'h2, 1'h0, FWS_RES_DONE);
    run(1'h0, 1'h0, 1'h1, 2'h2, 4'h1, 1'h1, FWS_RES_FAIL);
    run(1'h0, 1'h1, 1'h1, 2'h3, 4'h0, 1'h0, FWS_RES_SUSPEND);
    run(1'h1, 1'h0, 1'h0, 2'h1, 4'h1, 1'h1, FWS_RES_FAIL);
    run(1'h0, 1'h0, 1'h0, 2'h1, 4'h0, 1'h0, FWS_RES_DONE);
    end_of_test;
  end
endmodule : testbench
